// ---- inc/tlo_params.svh ----
`ifndef TLO_PARAMS_SVH
`define TLO_PARAMS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define TLO_IDX_LIM_LO 6'h0a
`define TLO_IDX_LIM_HI 6'h0b
`define TLO_IDX_CORR_LO 6'h0c
`define TLO_IDX_CORR_HI 6'h0d
`define TLO_IDX_PIN_RB 6'h0e
`define TLO_IDX_PIN_FN 6'h0f
`define TLO_IDX_RESULT 6'h10
`define TLO_IDX_STATUS 6'h11
`define TLO_IDX_CMD 6'h12

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TLO_RST_LIM_LO 8'hf0
`define TLO_RST_LIM_HI 8'h07
`define TLO_RST_CORR_LO 8'h00
`define TLO_RST_CORR_HI 8'h00
`define TLO_RST_PIN_RB 8'hf0
`define TLO_RST_PIN_FN 8'h00
`define TLO_RST_RESULT 16'h0000

// ------------------------------------------------------------
// Field positions and codes
// ------------------------------------------------------------
`define TLO_STAT_ALERT_FLAG 0
`define TLO_STAT_ALERT_LIVE 1
`define TLO_STAT_LOADING 2
`define TLO_CMD_COPY 0
`define TLO_CMD_PIN_READ 1
`define TLO_PIN_INV_LSB 4
`define TLO_FN_INPUT 2'h0
`define TLO_FN_ALERT 2'h1
`define TLO_FN_DRIVE_LOW 2'h2
`define TLO_FN_RELEASE 2'h3
`define TLO_ALERT_PIN 2

`endif

// ---- inc/tlo_pkg.sv ----
package tlo_pkg;

    // Nonvolatile image of the calibration and limit bytes
    typedef struct packed {
        logic [7:0] corr_hi;
        logic [7:0] corr_lo;
        logic [7:0] lim_hi;
        logic [7:0] lim_lo;
    } tlo_nvm_image_t;

    // Four general-purpose open-drain pins
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] drive;
        logic [3:0] oe;
    } tlo_pins_t;

    // One-hot power-up sequencer
    typedef enum logic [1:0] {
        TLO_ST_LOAD = 2'b01,
        TLO_ST_RUN = 2'b10
    } tlo_state_t;

endpackage

// ---- logic/tlo_regs.sv ----
// Function
// - Corrected result above high limit sets sticky high-alert status flag.
// - Alert-search command answered with alert bit while high alert holds.
// - Supply-powered device pulls alert pin low during high alert.
// - High limit is 16 bits; low byte at 0Ah resets F0h, high at 0Bh.
// - High limit high byte resets to 07h.
// - Copy command stores limit and correction bytes into nonvolatile memory.
// - Power-on reset reloads limit and correction from nonvolatile memory.
// - Factory contents of limit and correction use legacy temperature format.
// - Every conversion adds stored correction before storing the result.
// - Comparison uses the corrected result, never the raw value.
// - Correction is 16 bits at 0Ch and 0Dh, both reset zero.
// - Pin readback refreshes only on the pin-read command.
// - Readback bits 3:0 show true pin levels, reset zero.
// - Readback bits 7:4 show inverted levels, reset ones, register F0h.
// - Pin two in alert function reads back the alert output state.
// - Pin three field 7:6: input, reserved, drive low, release.
// - Pin function register resets to zero and is write-only.
//
// Implementation choice: the APB register port.
`include "tlo_params.svh"

module tlo_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_done,
    input wire logic [15:0] conv_raw,
    input wire logic vdd_powered,
    input wire logic alert_search_req,
    output logic alert_search_hit,
    output logic alert_pin_out,
    output logic alert_pin_oe,
    input wire logic [3:0] io_in,
    output tlo_pkg::tlo_pins_t io_pins,
    input wire tlo_pkg::tlo_nvm_image_t nvm_rd_data,
    input wire logic nvm_rd_valid,
    output tlo_pkg::tlo_nvm_image_t nvm_wr_data,
    output logic nvm_wr_en
);
    import tlo_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    tlo_state_t state_r;
    tlo_state_t state_nxt;
    logic [7:0] lim_lo_r;
    logic [7:0] lim_hi_r;
    logic [7:0] corr_lo_r;
    logic [7:0] corr_hi_r;
    logic [7:0] pin_rb_r;
    logic [7:0] pin_fn_r;
    logic [15:0] result_r;
    logic alert_live_r;
    logic alert_flag_r;
    logic [31:0] prdata_r;
    logic search_hit_r;
    logic nvm_wr_en_r;
    tlo_nvm_image_t nvm_wr_data_r;
    logic [7:0] lim_lo_nxt;
    logic [7:0] lim_hi_nxt;
    logic [7:0] corr_lo_nxt;
    logic [7:0] corr_hi_nxt;
    logic [7:0] pin_rb_nxt;
    logic [7:0] pin_fn_nxt;
    logic [15:0] result_nxt;
    logic alert_live_nxt;
    logic alert_flag_nxt;
    logic [31:0] prdata_nxt;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire loading = (state_r == TLO_ST_LOAD);
    wire setup_ph = psel && !penable;
    wire wr_ok = psel && penable && pwrite && pready;
    wire [5:0] idx = paddr[7:2];
    wire hit_lim_lo = (idx == `TLO_IDX_LIM_LO);
    wire hit_lim_hi = (idx == `TLO_IDX_LIM_HI);
    wire hit_corr_lo = (idx == `TLO_IDX_CORR_LO);
    wire hit_corr_hi = (idx == `TLO_IDX_CORR_HI);
    wire hit_pin_rb = (idx == `TLO_IDX_PIN_RB);
    wire hit_pin_fn = (idx == `TLO_IDX_PIN_FN);
    wire hit_result = (idx == `TLO_IDX_RESULT);
    wire hit_status = (idx == `TLO_IDX_STATUS);
    wire hit_cmd = (idx == `TLO_IDX_CMD);
    wire mapped = hit_lim_lo || hit_lim_hi || hit_corr_lo || hit_corr_hi
        || hit_pin_rb || hit_pin_fn || hit_result || hit_status || hit_cmd;
    wire cmd_copy = wr_ok && hit_cmd && pwdata[`TLO_CMD_COPY];
    wire cmd_pin_read = wr_ok && hit_cmd && pwdata[`TLO_CMD_PIN_READ];
    wire stat_clear = wr_ok && hit_status && pwdata[`TLO_STAT_ALERT_FLAG];

    // Bus is held off while the power-up reload is still pending
    assign pready = !loading;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------
    // Power-up reload sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TLO_ST_LOAD: begin
                if (nvm_rd_valid) begin
                    state_nxt = TLO_ST_RUN;
                end
            end
            TLO_ST_RUN: begin
                state_nxt = TLO_ST_RUN;
            end
            default: begin
                state_nxt = TLO_ST_LOAD;
            end
        endcase
    end

    wire do_load = loading && nvm_rd_valid;

    // ------------------------------------------------------------
    // Limit and correction bytes
    // ------------------------------------------------------------
    // Reload wins over software, which is stalled during load anyway
    assign lim_lo_nxt = do_load ? nvm_rd_data.lim_lo :
        (wr_ok && hit_lim_lo) ? pwdata[7:0] : lim_lo_r;
    assign lim_hi_nxt = do_load ? nvm_rd_data.lim_hi :
        (wr_ok && hit_lim_hi) ? pwdata[7:0] : lim_hi_r;
    assign corr_lo_nxt = do_load ? nvm_rd_data.corr_lo :
        (wr_ok && hit_corr_lo) ? pwdata[7:0] : corr_lo_r;
    assign corr_hi_nxt = do_load ? nvm_rd_data.corr_hi :
        (wr_ok && hit_corr_hi) ? pwdata[7:0] : corr_hi_r;

    // ------------------------------------------------------------
    // Conversion correction and high-alert compare
    // ------------------------------------------------------------
    // Signed add wraps on overflow; the format leaves headroom for it
    wire signed [15:0] corr_s = {corr_hi_r, corr_lo_r};
    wire signed [15:0] lim_s = {lim_hi_r, lim_lo_r};
    wire signed [15:0] raw_s = conv_raw;
    wire signed [15:0] fixed_s = raw_s + corr_s;
    wire over_lim = (fixed_s > lim_s);
    assign result_nxt = conv_done ? fixed_s : result_r;
    assign alert_live_nxt = conv_done ? over_lim : alert_live_r;
    // Set beats clear so an alert in the clearing cycle is kept
    assign alert_flag_nxt = (conv_done && over_lim) ||
        (alert_flag_r && !stat_clear);

    // ------------------------------------------------------------
    // Alert pin and pins 0 to 3
    // ------------------------------------------------------------
    // Bus-powered parts never drive the alert pin
    wire alert_drive = vdd_powered && alert_live_r;
    assign alert_pin_out = 1'b0;
    assign alert_pin_oe = alert_drive;

    logic [3:0] pin_level;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pin
            wire [1:0] fn = pin_fn_r[2*g+1:2*g];
            // Reserved code behaves as an input
            wire own_alert = (g == `TLO_ALERT_PIN) && (fn == `TLO_FN_ALERT);
            assign io_pins.drive[g] = 1'b0;
            assign io_pins.oe[g] = (fn == `TLO_FN_DRIVE_LOW) ||
                (own_alert && alert_drive);
            // Alert-mode pin two reports the alert output, not the pad
            assign pin_level[g] = own_alert ? !alert_drive : io_in[g];
        end
    endgenerate
    assign io_pins.level = pin_level;

    // Snapshot only on command so software sees a coherent sample
    assign pin_rb_nxt = cmd_pin_read ? {~pin_level, pin_level} :
        pin_rb_r;
    assign pin_fn_nxt = (wr_ok && hit_pin_fn) ? pwdata[7:0] : pin_fn_r;

    // ------------------------------------------------------------
    // Read data, captured in setup and again while the bus waits
    // ------------------------------------------------------------
    // Next values are used so a read stalled by the reload returns
    // the reloaded bytes, not the reset values
    wire rd_capture = setup_ph || (psel && !pready);
    wire [31:0] status_word = {29'h0, loading, alert_live_r, alert_flag_r};
    assign prdata_nxt = !rd_capture ? prdata_r :
        hit_lim_lo ? {24'h0, lim_lo_nxt} :
        hit_lim_hi ? {24'h0, lim_hi_nxt} :
        hit_corr_lo ? {24'h0, corr_lo_nxt} :
        hit_corr_hi ? {24'h0, corr_hi_nxt} :
        hit_pin_rb ? {24'h0, pin_rb_r} :
        hit_result ? {16'h0, result_r} :
        hit_status ? status_word :
        32'h0;

    // ------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= TLO_ST_LOAD;
            lim_lo_r <= `TLO_RST_LIM_LO;
            lim_hi_r <= `TLO_RST_LIM_HI;
            corr_lo_r <= `TLO_RST_CORR_LO;
            corr_hi_r <= `TLO_RST_CORR_HI;
        end else begin
            state_r <= state_nxt;
            lim_lo_r <= lim_lo_nxt;
            lim_hi_r <= lim_hi_nxt;
            corr_lo_r <= corr_lo_nxt;
            corr_hi_r <= corr_hi_nxt;
        end
    end

    // Pin, result and alert state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_rb_r <= `TLO_RST_PIN_RB;
            pin_fn_r <= `TLO_RST_PIN_FN;
            result_r <= `TLO_RST_RESULT;
            alert_live_r <= 1'b0;
            alert_flag_r <= 1'b0;
        end else begin
            pin_rb_r <= pin_rb_nxt;
            pin_fn_r <= pin_fn_nxt;
            result_r <= result_nxt;
            alert_live_r <= alert_live_nxt;
            alert_flag_r <= alert_flag_nxt;
        end
    end

    // Bus answer, search answer and nonvolatile write strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
            search_hit_r <= 1'b0;
            nvm_wr_en_r <= 1'b0;
            nvm_wr_data_r <= '0;
        end else begin
            prdata_r <= prdata_nxt;
            search_hit_r <= alert_search_req && alert_live_r;
            nvm_wr_en_r <= cmd_copy;
            if (cmd_copy) begin
                nvm_wr_data_r <= {corr_hi_r, corr_lo_r, lim_hi_r, lim_lo_r};
            end
        end
    end

    assign prdata = prdata_r;
    assign alert_search_hit = search_hit_r;
    assign nvm_wr_en = nvm_wr_en_r;
    assign nvm_wr_data = nvm_wr_data_r;

endmodule // tlo_regs

// ---- tb/tlo_regs_properties.sv ----
`include "tlo_params.svh"
// ------------------------------------------
// Pin-level checks on the register block
// ------------------------------------------
module tlo_regs_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic vdd_powered,
    input wire logic alert_search_req,
    input wire logic alert_search_hit,
    input wire logic alert_pin_oe,
    input wire tlo_pkg::tlo_pins_t io_pins,
    input wire logic nvm_rd_valid,
    input wire logic nvm_wr_en
);
    timeunit 1ns;
    timeprecision 1ps;
    import tlo_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access decode shared by the checks
    wire acc = psel && penable && pready;
    wire [5:0] idx = paddr[7:2];
    wire copy_wr = acc && pwrite && idx == `TLO_IDX_CMD && pwdata[0];
    wire fn_wr = acc && pwrite && idx == `TLO_IDX_PIN_FN;
    wire [1:0] fn3 = pwdata[7:6];
    AST_SEARCH_CAUSE: assert property (
        alert_search_hit |-> $past(alert_search_req))
        else $error("search hit without a request");
    // Both samples low, though the pin enable follows vdd_powered without a register
    AST_BUS_POWERED_QUIET: assert property (
        !vdd_powered && !$past(vdd_powered) |-> !alert_pin_oe)
        else $error("alert pin pulled while bus powered");
    AST_COPY_STROBE: assert property (
        copy_wr |=> nvm_wr_en)
        else $error("copy command gave no store strobe");
    AST_STORE_CAUSE: assert property (
        nvm_wr_en |-> $past(copy_wr))
        else $error("store strobe without copy command");
    AST_STORE_PULSE: assert property (
        nvm_wr_en |=> !nvm_wr_en)
        else $error("store strobe longer than one cycle");
    AST_WAIT_RELOAD: assert property (
        !pready && !nvm_rd_valid |=> !pready)
        else $error("bus served before reload");
    AST_PIN3_FUNCTION: assert property (
        fn_wr |=> io_pins.oe[3] == ($past(fn3) == 2'h2))
        else $error("pin three enable does not follow its code");
    AST_OPEN_DRAIN: assert property (
        io_pins.drive == 4'h0)
        else $error("pin driven high");
    AST_FUNCTION_WO: assert property (
        acc && !pwrite && idx == `TLO_IDX_PIN_FN |-> prdata == 32'h0)
        else $error("pin function register readable");
    cover property (copy_wr);
    cover property (alert_search_hit);
    cover property (fn_wr && fn3 == 2'h2);
endmodule // tlo_regs_chk

// ---- tb/tlo_nvm_model.sv ----
`include "tlo_params.svh"
// ------------------------------------------
// Nonvolatile store behind the block
// ------------------------------------------
module tlo_nvm_model (
    input wire logic pclk,
    input wire logic presetn,
    output tlo_pkg::tlo_nvm_image_t nvm_rd_data,
    output logic nvm_rd_valid,
    input wire tlo_pkg::tlo_nvm_image_t nvm_wr_data,
    input wire logic nvm_wr_en
);
    timeunit 1ns;
    timeprecision 1ps;
    import tlo_pkg::*;
    // Factory image in the legacy format
    tlo_nvm_image_t mem_r = {8'h00, 8'h00, 8'h07, 8'hf0};
    logic [2:0] wait_r;
    // Slow reload; bus shows garbage until valid
    assign nvm_rd_valid = wait_r == 3'h5;
    assign nvm_rd_data = nvm_rd_valid ? mem_r : ~mem_r;
    // Count off the reload delay, then store on each strobe
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 3'h0;
        end else if (wait_r != 3'h5) begin
            wait_r <= wait_r + 3'h1;
        end
        if (presetn && nvm_wr_en) begin
            mem_r <= nvm_wr_data;
        end
    end
endmodule // tlo_nvm_model

// ---- tb/tb.sv ----
`include "tlo_params.svh"
bind tlo_regs tlo_regs_chk tlo_regs_chk_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .vdd_powered(vdd_powered), .alert_search_req(alert_search_req),
    .alert_search_hit(alert_search_hit), .alert_pin_oe(alert_pin_oe),
    .io_pins(io_pins), .nvm_rd_valid(nvm_rd_valid), .nvm_wr_en(nvm_wr_en));
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tlo_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic conv_done, vdd_powered, alert_search_req, alert_search_hit;
    logic alert_pin_out, alert_pin_oe, nvm_rd_valid, nvm_wr_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] conv_raw;
    logic [3:0] io_in;
    tlo_pins_t io_pins;
    tlo_nvm_image_t nvm_rd_data, nvm_wr_data;
    int err_count = 0;
    int cmp_count = 0;
    logic last_err;
    tlo_regs tlo_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_done(conv_done), .conv_raw(conv_raw),
        .vdd_powered(vdd_powered), .alert_search_req(alert_search_req),
        .alert_search_hit(alert_search_hit), .alert_pin_out(alert_pin_out),
        .alert_pin_oe(alert_pin_oe), .io_in(io_in), .io_pins(io_pins),
        .nvm_rd_data(nvm_rd_data), .nvm_rd_valid(nvm_rd_valid),
        .nvm_wr_data(nvm_wr_data), .nvm_wr_en(nvm_wr_en));
    tlo_nvm_model tlo_nvm_model_inst (.pclk(pclk), .presetn(presetn),
        .nvm_rd_data(nvm_rd_data), .nvm_rd_valid(nvm_rd_valid),
        .nvm_wr_data(nvm_wr_data), .nvm_wr_en(nvm_wr_en));
    // ------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------
    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask
    // Answer and error are taken at the edge that sees pready high
    task automatic apb(input logic w, input logic [5:0] i,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [5:0] i,
                      input logic [31:0] x);
        logic [31:0] q;
        apb(1'b0, i, 32'h0, q);
        chk(n, x, q);
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, i, {24'h0, d}, q);
    endtask
    task automatic conv(input logic [15:0] r);
        @(posedge pclk);
        conv_done <= 1'b1;
        conv_raw <= r;
        @(posedge pclk);
        conv_done <= 1'b0;
    endtask
    task automatic srch(input logic x);
        @(posedge pclk);
        alert_search_req <= 1'b1;
        @(posedge pclk);
        alert_search_req <= 1'b0;
        @(negedge pclk);
        chk("hit", {31'h0, x}, {31'h0, alert_search_hit});
    endtask
    task automatic rst();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic conclude();
        $display("compares %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Clock and a watchdog well beyond the sequence length
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (3000) @(posedge pclk);
        err_count++;
        conclude();
    end
    // ------------------------------------------
    // Test sequence
    // ------------------------------------------
    initial begin
        {psel, penable, pwrite, conv_done, alert_search_req} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        conv_raw = 16'h0;
        io_in = 4'ha;
        vdd_powered = 1'b1;
        rst();
        rd("lim_lo", `TLO_IDX_LIM_LO, 32'hf0);
        rd("lim_hi", `TLO_IDX_LIM_HI, 32'h07);
        rd("corr_lo", `TLO_IDX_CORR_LO, 32'h00);
        rd("corr_hi", `TLO_IDX_CORR_HI, 32'h00);
        rd("pin_rb", `TLO_IDX_PIN_RB, 32'hf0);
        rd("pin_fn", `TLO_IDX_PIN_FN, 32'h00);
        chk("slverr", 32'h0, {31'h0, last_err});
        rd("unmapped", 6'h3f, 32'h0);
        chk("slverr", 32'h1, {31'h0, last_err});
        wr(`TLO_IDX_CMD, 8'h02);
        io_in <= 4'hf;
        rd("pin_rb", `TLO_IDX_PIN_RB, 32'h5a);
        for (int c = 0; c < 4; c++) begin
            wr(`TLO_IDX_PIN_FN, 8'(c << 6));
            @(negedge pclk);
            chk("oe3", {31'h0, c == 2}, {31'h0, io_pins.oe[3]});
        end
        // Limit 0100h, correction +10h: only the corrected value trips
        wr(`TLO_IDX_LIM_LO, 8'h00);
        wr(`TLO_IDX_LIM_HI, 8'h01);
        wr(`TLO_IDX_CORR_LO, 8'h10);
        wr(`TLO_IDX_CORR_HI, 8'h00);
        conv(16'h00f0);
        rd("result", `TLO_IDX_RESULT, 32'h0100);
        rd("status", `TLO_IDX_STATUS, 32'h0);
        srch(1'b0);
        conv(16'h00f1);
        rd("status", `TLO_IDX_STATUS, 32'h3);
        srch(1'b1);
        chk("alert_oe", 32'h1, {31'h0, alert_pin_oe});
        chk("alert_out", 32'h0, {31'h0, alert_pin_out});
        vdd_powered <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("alert_oe", 32'h0, {31'h0, alert_pin_oe});
        vdd_powered <= 1'b1;
        wr(`TLO_IDX_PIN_FN, 8'h10);
        wr(`TLO_IDX_CMD, 8'h02);
        rd("pin_rb", `TLO_IDX_PIN_RB, 32'h4b);
        // Negative correction must not look like a huge positive value
        wr(`TLO_IDX_CORR_LO, 8'hf0);
        wr(`TLO_IDX_CORR_HI, 8'hff);
        conv(16'h0000);
        rd("result", `TLO_IDX_RESULT, 32'hfff0);
        rd("status", `TLO_IDX_STATUS, 32'h1);
        wr(`TLO_IDX_STATUS, 8'h01);
        rd("status", `TLO_IDX_STATUS, 32'h0);
        wr(`TLO_IDX_CMD, 8'h01);
        repeat (3) @(posedge pclk);
        rst();
        rd("lim_lo", `TLO_IDX_LIM_LO, 32'h00);
        rd("lim_hi", `TLO_IDX_LIM_HI, 32'h01);
        rd("corr_lo", `TLO_IDX_CORR_LO, 32'hf0);
        rd("corr_hi", `TLO_IDX_CORR_HI, 32'hff);
        conclude();
    end
endmodule // tb
